//--- pbiw_pkg.sv
package pbiw_pkg;

  // ****************************************
  // bus shape
  // ****************************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 2;

  // ****************************************
  // device register map
  // ****************************************
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 2'h2;

  localparam int CTRL_IRQ_EN_BIT = 0;
  localparam int CTRL_DMA_EN_BIT = 1;
  localparam int CTRL_AUTO_BIT   = 2;
  localparam logic [2:0] CTRL_RESET = 3'h5;

  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_IRQ_BIT   = 1;
  localparam int STAT_BLOCK_BIT = 2;
  localparam int STAT_FIFO_BIT  = 3;

  // ****************************************
  // synchroniser lanes of the device
  // ****************************************
  localparam int SYN_RST   = 5;
  localparam int SYN_CS    = 4;
  localparam int SYN_RD    = 3;
  localparam int SYN_WR    = 2;
  localparam int SYN_GRANT = 1;
  localparam int SYN_LAST  = 0;
  localparam logic [5:0] SYN_IDLE = 6'h3E;

  // ****************************************
  // timing counts in clk cycles, block length in transfers
  // ****************************************
  localparam logic [3:0] DEV_WAIT_CYCLES  = 4'h4;
  localparam logic [3:0] HOST_STROBE_MIN  = 4'h8;
  localparam logic [3:0] HOST_RECOVER     = 4'h8;
  localparam int         HOST_BLOCK_LEN   = 8;

  // ****************************************
  // host sequencer
  // ****************************************
  typedef enum logic [2:0] {
    PBIW_IDLE    = 3'h0,
    PBIW_SETUP   = 3'h1,
    PBIW_STROBE  = 3'h3,
    PBIW_FINISH  = 3'h2,
    PBIW_RECOVER = 3'h6
  } pbiw_host_state_t;

endpackage

//--- pbiw_bus_if.sv
`timescale 1ns/1ps
interface pbiw_bus_if (
  input wire logic clk
);
  import pbiw_pkg::*;

  logic [DATA_W-1:0] dataHost;
  logic              dataHostOe;
  logic [DATA_W-1:0] dataDev;
  logic              dataDevOe;
  logic [DATA_W-1:0] dataBus;
  logic [ADDR_W-1:0] addr;
  logic              csN;
  logic              periphReadStrobeN;
  logic              periphWriteStrobeN;
  logic              memoryReadStrobeN;
  logic              memoryWriteStrobeN;
  logic              resetN;
  logic              irqOut;
  logic              xferRequest;
  logic              xferGrantN;
  logic              blockLastCycle;
  logic              readyDevOut;
  logic              readyDevOe;
  logic              readyLine;

  // undriven lines float high through the pull-ups
  assign dataBus   = dataDevOe ? dataDev : (dataHostOe ? dataHost : 8'hFF);
  assign readyLine = readyDevOe ? readyDevOut : 1'b1;

  modport dev (
    input  dataBus, addr, csN, periphReadStrobeN, periphWriteStrobeN,
    input  resetN, xferGrantN, blockLastCycle, readyLine,
    output dataDev, dataDevOe, irqOut, xferRequest, readyDevOut, readyDevOe
  );

  modport host (
    input  dataBus, irqOut, xferRequest, readyLine,
    output dataHost, dataHostOe, addr, csN, periphReadStrobeN,
    output periphWriteStrobeN, memoryReadStrobeN, memoryWriteStrobeN,
    output resetN, xferGrantN, blockLastCycle
  );
endinterface

//--- pbiw_device.sv
`timescale 1ns/1ps
module pbiw_fifo
  import pbiw_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output wire logic             inReady,
  output wire logic [WIDTH-1:0] outData,
  output wire logic             outValid,
  input  wire logic             outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR   = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [AW:0]                 count;
    logic                        full;
  } pbiw_fifo_state_t;

  pbiw_fifo_state_t s_reg;
  pbiw_fifo_state_t s_next;
  logic             doWr;
  logic             doRd;

  function automatic logic [AW-1:0] stepPtr(input logic [AW-1:0] p);
    stepPtr = (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction

  assign inReady  = ~s_reg.full;
  assign outValid = (s_reg.count != '0);
  assign outData  = s_reg.mem[s_reg.rdPtr];

  always_comb begin
    s_next = s_reg;
    doWr   = inValid & ~s_reg.full;
    doRd   = outReady & (s_reg.count != '0);
    if (doWr) begin
      s_next.mem[s_reg.wrPtr] = inData;
      s_next.wrPtr            = stepPtr(s_reg.wrPtr);
    end
    if (doRd) begin
      s_next.rdPtr = stepPtr(s_reg.rdPtr);
    end
    if (doWr && !doRd) begin
      s_next.count = s_reg.count + 1'b1;
    end else if (doRd && !doWr) begin
      s_next.count = s_reg.count - 1'b1;
    end
    s_next.full = (s_next.count == FULL_COUNT);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// Function
// - interrupt request is active high level
// - request holds until host services it
// - host services via programmed read or write
// - request may rise at any time
// - strobe completion at service address drops request
// - new result raises request, no done pin
// - result read clears request, starts next
// - control and status registers steer behaviour
// - device drives its own transfer request
// - host answers with dedicated grant
// - host flags last cycle of block
// - host pairs peripheral read with memory write
// - grant acts as a special chip select
// - slow device offers ready to stretch strobes
// - ready only pulls low or floats
// - host opens access with select and strobe
// - ready held low until data settled
// - ready used only for access stretching
// - select is level used, never edges
// - drive data only during selected read
// - selected write strobe captures data bus
// - low bus reset clears state, floats outputs
module pbiw_device
  import pbiw_pkg::*;
#(
  parameter int       FIFO_DEPTH  = 8,
  parameter logic [3:0] WAIT_CYCLES = DEV_WAIT_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst,
  pbiw_bus_if.dev                bus,
  input  wire logic [DATA_W-1:0] sampleData,
  input  wire logic              sampleValid,
  output wire logic              sampleReady,
  output wire logic              convStart
);
  typedef struct packed {
    logic [5:0]        sync1;
    logic [5:0]        sync2;
    logic              accRd;
    logic              accWr;
    logic              accDma;
    logic              accLast;
    logic [ADDR_W-1:0] accAddr;
    logic [DATA_W-1:0] wrData;
    logic [3:0]        waitCnt;
    logic              readyPull;
    logic              dataOe;
    logic [DATA_W-1:0] dataOut;
    logic              irq;
    logic              xfer_request;
    logic              blockDone;
    logic [2:0]        ctrl;
    logic [DATA_W-1:0] result;
    logic              resultValid;
    logic              convStart;
  } pbiw_dev_state_t;

  pbiw_dev_state_t   s_reg;
  pbiw_dev_state_t   s_next;
  logic [DATA_W-1:0] fifoData;
  logic              fifoValid;
  logic              fifoPop;
  logic              rdAct;
  logic              wrAct;
  logic              dmaAct;
  logic              consume;

  // ****************************************
  // sample buffer in front of the result
  // ****************************************
  pbiw_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) i_pbiw_fifo (
    .clk      (clk),
    .rst      (rst | ~s_reg.sync2[SYN_RST]),
    .inData   (sampleData),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  function automatic logic [DATA_W-1:0] readMux(
    input logic [ADDR_W-1:0] a,
    input pbiw_dev_state_t   st,
    input logic              fv
  );
    logic [DATA_W-1:0] stat;
    stat                 = '0;
    stat[STAT_VALID_BIT] = st.resultValid;
    stat[STAT_IRQ_BIT]   = st.irq;
    stat[STAT_BLOCK_BIT] = st.blockDone;
    stat[STAT_FIFO_BIT]  = fv;
    if (a == ADDR_RESULT) begin
      readMux = st.result;
    end else if (a == ADDR_CTRL) begin
      readMux = {5'h00, st.ctrl};
    end else if (a == ADDR_STATUS) begin
      readMux = stat;
    end else begin
      readMux = 8'h00;
    end
  endfunction

  // ****************************************
  // bus-facing sequencing
  // ****************************************
  always_comb begin
    s_next       = s_reg;
    fifoPop      = 1'b0;
    consume      = 1'b0;
    s_next.sync1 = {bus.resetN, bus.csN, bus.periphReadStrobeN,
                    bus.periphWriteStrobeN, bus.xferGrantN,
                    bus.blockLastCycle};
    s_next.sync2 = s_reg.sync1;
    // select and grant are only ever looked at as levels
    rdAct  = ~s_reg.sync2[SYN_RD] & ~s_reg.sync2[SYN_CS];
    wrAct  = ~s_reg.sync2[SYN_WR] & ~s_reg.sync2[SYN_CS];
    dmaAct = ~s_reg.sync2[SYN_RD] & ~s_reg.sync2[SYN_GRANT];
    s_next.convStart = 1'b0;

    if (!s_reg.accRd && !s_reg.accWr && (rdAct || dmaAct)) begin
      s_next.accRd     = 1'b1;
      s_next.accDma    = dmaAct;
      s_next.accLast   = dmaAct & s_reg.sync2[SYN_LAST];
      s_next.accAddr   = bus.addr;
      s_next.dataOut   = dmaAct ? s_reg.result
                                : readMux(bus.addr, s_reg, fifoValid);
      s_next.dataOe    = 1'b1;
      s_next.waitCnt   = WAIT_CYCLES;
      s_next.readyPull = 1'b1;
    end else if (!s_reg.accRd && !s_reg.accWr && wrAct) begin
      s_next.accWr     = 1'b1;
      s_next.accAddr   = bus.addr;
      s_next.waitCnt   = WAIT_CYCLES;
      s_next.readyPull = 1'b1;
    end else if (s_reg.accRd && !(rdAct || dmaAct)) begin
      s_next.accRd     = 1'b0;
      s_next.dataOe    = 1'b0;
      s_next.readyPull = 1'b0;
      consume = s_reg.accDma | (s_reg.accAddr == ADDR_RESULT);
      if (s_reg.accDma && s_reg.accLast) begin
        s_next.blockDone = 1'b1;
      end
    end else if (s_reg.accWr && !wrAct) begin
      s_next.accWr     = 1'b0;
      s_next.readyPull = 1'b0;
      if (s_reg.accAddr == ADDR_CTRL) begin
        s_next.ctrl = s_reg.wrData[2:0];
      end
      consume = (s_reg.accAddr == ADDR_RESULT);
    end else if (s_reg.accRd || s_reg.accWr) begin
      // wait is bounded so ready never becomes a sync mechanism
      if (s_reg.waitCnt != 4'h0) begin
        s_next.waitCnt = s_reg.waitCnt - 4'h1;
      end
      s_next.readyPull = (s_reg.waitCnt > 4'h1);
      if (s_reg.accRd && s_reg.accDma && s_reg.sync2[SYN_LAST]) begin
        s_next.accLast = 1'b1;
      end
      if (s_reg.accWr && s_reg.waitCnt != 4'h0) begin
        // host data is gone before the synced strobe release shows up
        s_next.wrData = bus.dataBus;
      end
    end

    if (consume) begin
      s_next.irq         = 1'b0;
      s_next.resultValid = 1'b0;
      s_next.convStart   = s_reg.ctrl[CTRL_AUTO_BIT];
    end

    // a load waits one idle cycle so a block end is not cleared at once
    if (!s_reg.resultValid && !s_next.resultValid && fifoValid) begin
      fifoPop            = 1'b1;
      s_next.result      = fifoData;
      s_next.resultValid = 1'b1;
      s_next.blockDone   = 1'b0;
      if (s_reg.ctrl[CTRL_IRQ_EN_BIT]) begin
        s_next.irq = 1'b1;
      end
    end

    s_next.xfer_request = s_reg.ctrl[CTRL_DMA_EN_BIT] & s_next.resultValid &
                 ~s_next.blockDone & ~s_next.accDma;
    if (!s_next.accRd) begin
      s_next.accDma = 1'b0;
    end

    if (!s_reg.sync2[SYN_RST]) begin
      s_next = '{sync1: s_next.sync1, sync2: s_next.sync2,
                 ctrl: CTRL_RESET, default: '0};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg       <= '0;
      s_reg.sync1 <= SYN_IDLE;
      s_reg.sync2 <= SYN_IDLE;
      s_reg.ctrl  <= CTRL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.irqOut      = s_reg.irq;
  assign bus.xferRequest = s_reg.xfer_request;
  assign bus.dataDev     = s_reg.dataOut;
  assign bus.dataDevOe   = s_reg.dataOe & ~bus.periphReadStrobeN &
                           ~(bus.csN & bus.xferGrantN);
  // never drives high; the host owns the pull-up
  assign bus.readyDevOut = 1'b0;
  assign bus.readyDevOe  = s_reg.readyPull;
  assign convStart       = s_reg.convStart;
endmodule

//--- pbiw_host.sv
`timescale 1ns/1ps
module pbiw_host
  import pbiw_pkg::*;
#(
  parameter int         BLOCK_LEN  = HOST_BLOCK_LEN,
  parameter logic [3:0] STROBE_MIN = HOST_STROBE_MIN
) (
  input  wire logic              clk,
  input  wire logic              rst,
  pbiw_bus_if.host               bus,
  input  wire logic              cmdValid,
  input  wire logic              cmdWrite,
  input  wire logic [ADDR_W-1:0] cmdAddr,
  input  wire logic [DATA_W-1:0] cmdData,
  output wire logic              cmdReady,
  output wire logic              rspValid,
  output wire logic [DATA_W-1:0] rspData,
  input  wire logic              dmaEnable,
  output wire logic              dmaValid,
  output wire logic [DATA_W-1:0] dmaData,
  output wire logic              dmaBlockEnd,
  output wire logic              irqSeen
);
  localparam int CW = (BLOCK_LEN > 1) ? $clog2(BLOCK_LEN) : 1;
  localparam logic [CW-1:0] LAST_COUNT = CW'(BLOCK_LEN - 1);

  typedef struct packed {
    pbiw_host_state_t  state;
    logic [3:0]        cnt;
    logic [2:0]        sync1;
    logic [2:0]        sync2;
    logic              resetN;
    logic              csN;
    logic              rdN;
    logic              wrN;
    logic              memWrN;
    logic              grantN;
    logic              last;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dataOut;
    logic              dataOe;
    logic              isDma;
    logic              isWrite;
    logic [CW-1:0]     dmaCount;
    logic              cmdReady;
    logic              rspValid;
    logic              dmaValid;
    logic              dmaBlockEnd;
    logic [DATA_W-1:0] capData;
  } pbiw_host_reg_t;

  pbiw_host_reg_t s_reg;
  pbiw_host_reg_t s_next;
  logic           irqS;
  logic           drqS;
  logic           readyS;

  // ****************************************
  // access sequencer
  // ****************************************
  always_comb begin
    s_next             = s_reg;
    s_next.sync1       = {bus.irqOut, bus.xferRequest, bus.readyLine};
    s_next.sync2       = s_reg.sync1;
    irqS               = s_reg.sync2[2];
    drqS               = s_reg.sync2[1];
    readyS             = s_reg.sync2[0];
    s_next.resetN      = 1'b1;
    s_next.rspValid    = 1'b0;
    s_next.dmaValid    = 1'b0;
    s_next.dmaBlockEnd = 1'b0;
    case (s_reg.state)
      PBIW_IDLE: begin
        if (cmdValid && s_reg.cmdReady) begin
          s_next.cmdReady = 1'b0;
          s_next.addr     = cmdAddr;
          s_next.isWrite  = cmdWrite;
          s_next.isDma    = 1'b0;
          s_next.dataOut  = cmdData;
          s_next.csN      = 1'b0;
          s_next.state    = PBIW_SETUP;
        end else if (dmaEnable && drqS) begin
          s_next.cmdReady = 1'b0;
          s_next.isWrite  = 1'b0;
          s_next.isDma    = 1'b1;
          s_next.grantN   = 1'b0;
          s_next.last     = (s_reg.dmaCount == LAST_COUNT);
          s_next.state    = PBIW_SETUP;
        end
      end
      PBIW_SETUP: begin
        s_next.cnt = 4'h0;
        if (s_reg.isWrite) begin
          s_next.wrN    = 1'b0;
          s_next.dataOe = 1'b1;
        end else begin
          s_next.rdN    = 1'b0;
          s_next.memWrN = ~s_reg.isDma;
        end
        s_next.state = PBIW_STROBE;
      end
      PBIW_STROBE: begin
        if (s_reg.cnt != STROBE_MIN) begin
          s_next.cnt = s_reg.cnt + 4'h1;
        end else if (readyS) begin
          s_next.capData = bus.dataBus;
          s_next.rdN     = 1'b1;
          s_next.wrN     = 1'b1;
          s_next.memWrN  = 1'b1;
          s_next.state   = PBIW_FINISH;
        end
      end
      PBIW_FINISH: begin
        s_next.csN    = 1'b1;
        s_next.grantN = 1'b1;
        s_next.last   = 1'b0;
        s_next.dataOe = 1'b0;
        s_next.cnt    = 4'h0;
        if (s_reg.isDma) begin
          s_next.dmaValid    = 1'b1;
          s_next.dmaBlockEnd = s_reg.last;
          s_next.dmaCount    = s_reg.last ? '0 : s_reg.dmaCount + 1'b1;
        end else begin
          s_next.rspValid = 1'b1;
        end
        s_next.state = PBIW_RECOVER;
      end
      PBIW_RECOVER: begin
        // lets the request settle before it is sampled again
        if (s_reg.cnt != HOST_RECOVER) begin
          s_next.cnt = s_reg.cnt + 4'h1;
        end else begin
          s_next.cmdReady = 1'b1;
          s_next.state    = PBIW_IDLE;
        end
      end
      default: begin
        s_next.state = PBIW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg          <= '0;
      s_reg.state    <= PBIW_IDLE;
      s_reg.csN      <= 1'b1;
      s_reg.rdN      <= 1'b1;
      s_reg.wrN      <= 1'b1;
      s_reg.memWrN   <= 1'b1;
      s_reg.grantN   <= 1'b1;
      s_reg.cmdReady <= 1'b1;
      s_reg.sync1    <= 3'h1;
      s_reg.sync2    <= 3'h1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.resetN             = s_reg.resetN;
  assign bus.csN                = s_reg.csN;
  assign bus.periphReadStrobeN  = s_reg.rdN;
  assign bus.periphWriteStrobeN = s_reg.wrN;
  assign bus.memoryReadStrobeN  = 1'b1;
  assign bus.memoryWriteStrobeN = s_reg.memWrN;
  assign bus.xferGrantN         = s_reg.grantN;
  assign bus.blockLastCycle     = s_reg.last;
  assign bus.addr               = s_reg.addr;
  assign bus.dataHost           = s_reg.dataOut;
  assign bus.dataHostOe         = s_reg.dataOe;
  assign cmdReady               = s_reg.cmdReady;
  assign rspValid               = s_reg.rspValid;
  assign rspData                = s_reg.capData;
  assign dmaValid               = s_reg.dmaValid;
  assign dmaData                = s_reg.capData;
  assign dmaBlockEnd            = s_reg.dmaBlockEnd;
  assign irqSeen                = irqS;
endmodule

//--- pbiw_bus_properties.sv
`timescale 1ns/1ps
module pbiw_bus_properties
  import pbiw_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              csN,
  input wire logic              periphReadStrobeN,
  input wire logic              periphWriteStrobeN,
  input wire logic              memoryWriteStrobeN,
  input wire logic              resetN,
  input wire logic              irqOut,
  input wire logic              xferRequest,
  input wire logic              xferGrantN,
  input wire logic              blockLastCycle,
  input wire logic              dataHostOe,
  input wire logic              dataDevOe,
  input wire logic              readyDevOut,
  input wire logic              readyDevOe
);
  // ****************************************
  // helper state
  // ****************************************
  logic       svcReg;
  logic [3:0] rdAgeReg;
  logic       svcHit;
  logic       rdSel;
  assign svcHit = !csN && addr == ADDR_RESULT
                  && !(periphReadStrobeN && periphWriteStrobeN);
  assign rdSel = !periphReadStrobeN && (!csN || !xferGrantN);
  // a service stays remembered until the request has actually dropped
  always_ff @(posedge clk) begin
    if (rst || !resetN || svcHit) svcReg <= 1'b1;
    else if (!irqOut) svcReg <= 1'b0;
    if (rst) rdAgeReg <= 4'hF;
    else if (rdSel) rdAgeReg <= 4'h0;
    else if (rdAgeReg != 4'hF) rdAgeReg <= rdAgeReg + 4'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************************************
  // assertions
  // ****************************************
  irq_held_a: assert property (
    $fell(irqOut) |-> svcReg) else $error("irq dropped unserviced");
  dev_data_read_a: assert property (
    dataDevOe |-> rdAgeReg <= 4'h6) else $error("data driven off read");
  bus_clash_a: assert property (
    !(dataDevOe && dataHostOe)) else $error("both drive data");
  ready_pull_a: assert property (
    readyDevOe |-> !readyDevOut && !(csN && xferGrantN))
    else $error("ready misuse");
  ready_bound_a: assert property (
    $rose(readyDevOe) |-> ##[1:12] !readyDevOe) else $error("ready stuck");
  bus_reset_a: assert property (
    (!resetN)[*4] |-> !irqOut && !dataDevOe && !readyDevOe && !xferRequest)
    else $error("bus reset ignored");
  strobe_sel_a: assert property (
    !(periphReadStrobeN && periphWriteStrobeN) |-> csN != xferGrantN)
    else $error("strobe without one select");
  dma_pair_a: assert property (
    !xferGrantN && !periphReadStrobeN |-> !memoryWriteStrobeN)
    else $error("dma read without memory write");
  last_grant_a: assert property (
    $rose(blockLastCycle) |-> !xferGrantN) else $error("last without grant");
  req_drop_a: assert property (
    $fell(xferGrantN) && blockLastCycle |-> ##4 (!xferRequest)[*8])
    else $error("request kept after last");
endmodule

//--- pbiw_test.sv
`timescale 1ns/1ps
module pbiw_test;
  import pbiw_pkg::*;
  logic              clk, rst, hostRst, cmdValid, cmdWrite, cmdReady;
  logic              rspValid, dmaEnable, dmaValid, dmaBlockEnd, irqSeen;
  logic              sampleValid, sampleReady, convStart;
  logic [ADDR_W-1:0] cmdAddr;
  logic [DATA_W-1:0] cmdData, rspData, dmaData, sampleData, rd;
  int                errTotal, checks, cycles, convCount, endIdx, n, c0;
  logic [DATA_W-1:0] dmaQ[$];

  pbiw_bus_if i_pbiw_bus_if (.clk(clk));
  pbiw_host i_pbiw_host (.clk(clk), .rst(rst || hostRst),
    .bus(i_pbiw_bus_if), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspData(rspData), .dmaEnable(dmaEnable),
    .dmaValid(dmaValid), .dmaData(dmaData), .dmaBlockEnd(dmaBlockEnd),
    .irqSeen(irqSeen));
  pbiw_device i_pbiw_device (.clk(clk), .rst(rst), .bus(i_pbiw_bus_if),
    .sampleData(sampleData), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .convStart(convStart));
  pbiw_bus_properties i_pbiw_bus_properties (.clk(clk), .rst(rst),
    .addr(i_pbiw_bus_if.addr), .csN(i_pbiw_bus_if.csN),
    .periphReadStrobeN(i_pbiw_bus_if.periphReadStrobeN),
    .periphWriteStrobeN(i_pbiw_bus_if.periphWriteStrobeN),
    .memoryWriteStrobeN(i_pbiw_bus_if.memoryWriteStrobeN),
    .resetN(i_pbiw_bus_if.resetN), .irqOut(i_pbiw_bus_if.irqOut),
    .xferRequest(i_pbiw_bus_if.xferRequest),
    .xferGrantN(i_pbiw_bus_if.xferGrantN),
    .blockLastCycle(i_pbiw_bus_if.blockLastCycle),
    .dataHostOe(i_pbiw_bus_if.dataHostOe),
    .dataDevOe(i_pbiw_bus_if.dataDevOe),
    .readyDevOut(i_pbiw_bus_if.readyDevOut),
    .readyDevOe(i_pbiw_bus_if.readyDevOe));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic report_and_stop();
    if (errTotal == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input string name, input logic [7:0] exp, got);
    checks++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one host transfer; the host port paces the bus itself
  task automatic access(input logic wr, input logic [1:0] a,
                        input logic [7:0] d);
    int k;
    k = 0;
    @(negedge clk);
    while (cmdReady !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    cmdValid = 1'b1;
    cmdWrite = wr;
    cmdAddr = a;
    cmdData = d;
    @(negedge clk);
    cmdValid = 1'b0;
    k = 0;
    while (rspValid !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    if (rspValid !== 1'b1) errTotal++;
    rd = rspData;
  endtask

  task automatic readChk(input logic [1:0] a, input logic [7:0] exp,
                         input string name);
    access(1'b0, a, 8'h00);
    cmp(name, exp, rd);
  endtask

  task automatic push(input logic [7:0] d);
    int k;
    k = 0;
    @(negedge clk);
    while (sampleReady !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    if (sampleReady !== 1'b1) errTotal++;
    sampleValid = 1'b1;
    sampleData = d;
    @(negedge clk);
    sampleValid = 1'b0;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic tReset();
    readChk(ADDR_CTRL, 8'h05, "ctrl");
    readChk(ADDR_STATUS, 8'h00, "status");
    readChk(2'h3, 8'h00, "unmapped");
    cmp("irq", 8'h00, {7'h00, irqSeen});
  endtask

  task automatic tIrq();
    push(8'hA5);
    repeat (10) @(negedge clk);
    cmp("irq", 8'h01, {7'h00, irqSeen});
    readChk(ADDR_STATUS, 8'h03, "status");
    repeat (20) @(negedge clk);
    cmp("irq", 8'h01, {7'h00, irqSeen});
    c0 = convCount;
    readChk(ADDR_RESULT, 8'hA5, "result");
    repeat (8) @(negedge clk);
    cmp("irq", 8'h00, {7'h00, irqSeen});
    cmp("start", 8'h01, 8'(convCount - c0));
  endtask

  task automatic tWrite();
    access(1'b1, ADDR_CTRL, 8'h00);
    c0 = convCount;
    push(8'h3C);
    repeat (10) @(negedge clk);
    cmp("irq", 8'h00, {7'h00, irqSeen});
    readChk(ADDR_STATUS, 8'h01, "status");
    access(1'b1, ADDR_CTRL, 8'h01);
    readChk(ADDR_CTRL, 8'h01, "ctrl");
    access(1'b1, ADDR_RESULT, 8'h00);
    readChk(ADDR_STATUS, 8'h00, "status");
    cmp("start", 8'h00, 8'(convCount - c0));
  endtask

  // fill until refused: eight queued plus one held as the result
  task automatic tFifo();
    n = 0;
    @(negedge clk);
    while (sampleReady === 1'b1 && n < 20) begin
      sampleValid = 1'b1;
      sampleData = 8'h10 + 8'(n);
      n++;
      @(negedge clk);
    end
    sampleValid = 1'b0;
    cmp("accepted", 8'h09, 8'(n));
    for (int i = 0; i < 9; i++) begin
      readChk(ADDR_RESULT, 8'h10 + 8'(i), "drain");
    end
    readChk(ADDR_STATUS, 8'h00, "status");
  endtask

  task automatic tDma();
    access(1'b1, ADDR_CTRL, 8'h02);
    for (int i = 0; i < 8; i++) push(8'h40 + 8'(i));
    dmaEnable = 1'b1;
    n = 0;
    while (dmaQ.size() < 8 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    repeat (60) @(negedge clk);
    cmp("dma count", 8'h08, 8'(dmaQ.size()));
    for (int i = 0; i < 8 && i < dmaQ.size(); i++) begin
      cmp("dma data", 8'h40 + 8'(i), dmaQ[i]);
    end
    cmp("last", 8'h08, 8'(endIdx));
    dmaEnable = 1'b0;
    readChk(ADDR_STATUS, 8'h04, "status");
  endtask

  task automatic tBusReset();
    access(1'b1, ADDR_CTRL, 8'h07);
    hostRst = 1'b1;
    repeat (6) @(negedge clk);
    hostRst = 1'b0;
    readChk(ADDR_CTRL, 8'h05, "ctrl");
  endtask

  // pulses are registered, so the falling edge sees each one once
  always @(negedge clk) begin
    cycles++;
    if (convStart === 1'b1) convCount++;
    if (dmaValid === 1'b1) begin
      dmaQ.push_back(dmaData);
      if (dmaBlockEnd === 1'b1) endIdx = dmaQ.size();
    end
    if (cycles == 20000) begin
      errTotal++;
      report_and_stop();
    end
  end

  initial begin
    rst = 1'b1;
    hostRst = 1'b0;
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdAddr = '0;
    cmdData = 8'h00;
    dmaEnable = 1'b0;
    sampleValid = 1'b0;
    sampleData = 8'h00;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    tReset();
    tIrq();
    tWrite();
    tFifo();
    tDma();
    tBusReset();
    report_and_stop();
  end
endmodule
